// file: sosm_defs.vh
`ifndef SOSM_DEFS_VH
`define SOSM_DEFS_VH
// Clock rate in kHz, 125 MHz
`define SOSM_CLK_KHZ 125000
// Times in ms
`define SOSM_SYNC_SHORT_MS 500
`define SOSM_SYNC_LONG_MS 2000
`define SOSM_INTLK_MS 200
`define SOSM_INTLK_CLR_MS 1000
`define SOSM_SWON_MS 100
`define SOSM_RESP_MS 10
// Cycle counts derived from the times
`define SOSM_SYNC_SHORT_CYC (`SOSM_SYNC_SHORT_MS * `SOSM_CLK_KHZ)
`define SOSM_SYNC_LONG_CYC (`SOSM_SYNC_LONG_MS * `SOSM_CLK_KHZ)
`define SOSM_INTLK_CYC (`SOSM_INTLK_MS * `SOSM_CLK_KHZ)
`define SOSM_INTLK_CLR_CYC (`SOSM_INTLK_CLR_MS * `SOSM_CLK_KHZ)
`define SOSM_SWON_CYC (`SOSM_SWON_MS * `SOSM_CLK_KHZ)
`define SOSM_CNT_W 32
`define SOSM_CFG_W 2
`define SOSM_CFG_RST 2'h0
// Config bits
`define SOSM_CFG_INTLK 0
`define SOSM_CFG_SYNC 1
`endif

// file: sosm_timer.v
`timescale 1ns/1ps
`default_nettype none
`include "sosm_defs.vh"
// Up counter that saturates, restarted by clear
module sosm_timer (
  input wire clock,
  input wire rst_b,
  input wire clear,
  output reg [`SOSM_CNT_W-1:0] count_r
);
  always @(posedge clock) begin
    if (!rst_b || clear) begin
      count_r <= {`SOSM_CNT_W{1'b0}};
    end else if (count_r != {`SOSM_CNT_W{1'b1}}) begin
      count_r <= count_r + 32'h00000001;
    end
  end
endmodule // sosm_timer
`default_nettype wire

// file: sosm_ctrl.v
// What this block does
// - On power up enter initialization, run self-tests, outputs off.
// - Leave initialization only after self-test pass and switch-on delay.
// - Any detected error leads to the safe error state.
// - Energize only with start, inputs active, sync met, no interlock.
// - Channels not both active within sync time keep outputs off.
// - While energized, input deactivation de-energizes and returns to idle run.
// - Re-energize only after start and inputs are activated again.
// - Inactive start input keeps run-deenergized regardless of inputs.
// - Start met but inputs inactive keeps run-deenergized.
// - Only run-energized is outside the safe state.
// - Configuration accepted only in off/configuration state.
// - On entering run-deenergized, current input levels are evaluated first.
// - With start and valid sync, energize within the activation delay.
// - Sync window is 0.5 s or 2 s depending on first channel.
// - Second channel not deactivated within 200 ms raises interlock alert.
// - Interlock clears after both inputs held off at least one second.
// - Safe state holds all safety outputs de-energized.
`timescale 1ns/1ps
`default_nettype none
`include "sosm_defs.vh"
module sosm_ctrl #(
  parameter [`SOSM_CNT_W-1:0] SYNC_SHORT_CYC = `SOSM_SYNC_SHORT_CYC,
  parameter [`SOSM_CNT_W-1:0] SYNC_LONG_CYC = `SOSM_SYNC_LONG_CYC,
  parameter [`SOSM_CNT_W-1:0] INTLK_CYC = `SOSM_INTLK_CYC,
  parameter [`SOSM_CNT_W-1:0] INTLK_CLR_CYC = `SOSM_INTLK_CLR_CYC,
  parameter [`SOSM_CNT_W-1:0] SWON_CYC = `SOSM_SWON_CYC
) (
  input wire clock,
  input wire rst_b,
  input wire power_on,
  input wire chan_a_in,
  input wire chan_b_in,
  input wire start_in,
  input wire selftest_done,
  input wire selftest_pass,
  input wire error_in,
  input wire cfg_we,
  input wire [`SOSM_CFG_W-1:0] cfg_data,
  output reg safety_out_r,
  output reg [4:0] state_r,
  output reg interlock_alert_r,
  output reg sync_fail_r,
  output reg [`SOSM_CFG_W-1:0] cfg_r
);
  // One-hot operating states
  localparam [4:0] ST_OFF = 5'h01;
  localparam [4:0] ST_INIT = 5'h02;
  localparam [4:0] ST_IDLE = 5'h04;
  localparam [4:0] ST_RUN = 5'h08;
  localparam [4:0] ST_ERR = 5'h10;

  ////////////////////////////////////////////////////////////////////////////
  // Two-stage synchronisers for six pin inputs in one generate loop; power_on has its own pair, cfg pins are not synchronised
  wire [5:0] pin_raw;
  wire [5:0] pin_s;
  reg [5:0] meta_r;
  reg [5:0] sync_r;
  assign pin_raw = {error_in, selftest_pass, selftest_done, start_in, chan_b_in, chan_a_in};
  genvar gi;
  generate
    for (gi = 0; gi < 6; gi = gi + 1) begin : g_sync
      always @(posedge clock) begin
        if (!rst_b) begin
          meta_r[gi] <= 1'b0;
          sync_r[gi] <= 1'b0;
        end else begin
          meta_r[gi] <= pin_raw[gi];
          sync_r[gi] <= meta_r[gi];
        end
      end
    end
  endgenerate
  assign pin_s = sync_r;
  reg pwr_meta_r;
  reg pwr_r;
  always @(posedge clock) begin
    if (!rst_b) begin
      pwr_meta_r <= 1'b0;
      pwr_r <= 1'b0;
    end else begin
      pwr_meta_r <= power_on;
      pwr_r <= pwr_meta_r;
    end
  end
  wire a_s = pin_s[0];
  wire b_s = pin_s[1];
  wire st_s = pin_s[2];
  wire done_s = pin_s[3];
  wire pass_s = pin_s[4];
  wire err_s = pin_s[5];

  ////////////////////////////////////////////////////////////////////////////
  // Shared timers: switch-on, sync window, interlock window
  reg swon_clr;
  reg sync_clr;
  reg intlk_clr;
  wire [`SOSM_CNT_W-1:0] swon_cnt;
  wire [`SOSM_CNT_W-1:0] sync_cnt;
  wire [`SOSM_CNT_W-1:0] intlk_cnt;
  sosm_timer u_swon (.clock(clock), .rst_b(rst_b), .clear(swon_clr), .count_r(swon_cnt));
  sosm_timer u_sync (.clock(clock), .rst_b(rst_b), .clear(sync_clr), .count_r(sync_cnt));
  sosm_timer u_intlk (.clock(clock), .rst_b(rst_b), .clear(intlk_clr), .count_r(intlk_cnt));

  ////////////////////////////////////////////////////////////////////////////
  // Sync tracking: which channel came first, and whether second was in time
  reg a_first_r;
  reg sync_ok_r;
  reg armed_r;
  reg rearm_r;
  reg intlk_r;
  reg intlk_run_r;
  reg [4:0] state_nxt;
  wire both_on = a_s & b_s;
  wire both_off = ~a_s & ~b_s;
  wire one_on = a_s ^ b_s;
  wire [`SOSM_CNT_W-1:0] sync_lim = a_first_r ? SYNC_SHORT_CYC : SYNC_LONG_CYC;
  wire sync_use = cfg_r[`SOSM_CFG_SYNC];
  wire intlk_use = cfg_r[`SOSM_CFG_INTLK];
  // Start condition and full energize condition
  wire go = st_s & both_on & rearm_r & (sync_ok_r | ~sync_use) & ~(intlk_use & intlk_r);

  // Sync window: timer runs while exactly one channel is on
  always @(*) begin
    sync_clr = ~one_on;
    swon_clr = (state_r != ST_INIT);
    intlk_clr = ~intlk_run_r & ~(intlk_r & both_off);
  end

  always @(posedge clock) begin
    if (!rst_b) begin
      a_first_r <= 1'b0;
      sync_ok_r <= 1'b0;
      sync_fail_r <= 1'b0;
      armed_r <= 1'b0;
    end else begin
      if (both_off) begin
        sync_ok_r <= 1'b0;
        sync_fail_r <= 1'b0;
        armed_r <= 1'b1;
      end else if (one_on && sync_cnt == {`SOSM_CNT_W{1'b0}}) begin
        a_first_r <= a_s;
      end
      // A late second channel also voids an earlier good pairing
      if (one_on && sync_cnt >= sync_lim) begin
        sync_fail_r <= 1'b1;
        sync_ok_r <= 1'b0;
        armed_r <= 1'b0;
      end
      // Set on second channel in time; failed attempt needs both off again
      if (both_on && armed_r && !sync_fail_r) begin
        sync_ok_r <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interlock: after first drop both must be off within window
  always @(posedge clock) begin
    if (!rst_b) begin
      intlk_r <= 1'b0;
      intlk_run_r <= 1'b0;
      interlock_alert_r <= 1'b0;
    end else begin
      if (state_r == ST_RUN && one_on) begin
        intlk_run_r <= 1'b1;
      end else if (both_off) begin
        intlk_run_r <= 1'b0;
      end
      // Reactivation or timeout before the second drop
      if (intlk_run_r && (both_on || intlk_cnt >= INTLK_CYC)) begin
        intlk_r <= 1'b1;
        intlk_run_r <= 1'b0;
      end else if (intlk_r && both_off && intlk_cnt >= INTLK_CLR_CYC) begin
        intlk_r <= 1'b0;
      end
      interlock_alert_r <= intlk_r & intlk_use;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Start must be released and pressed anew after a stop
  always @(posedge clock) begin
    if (!rst_b) begin
      rearm_r <= 1'b0;
    end else if (state_r == ST_RUN) begin
      rearm_r <= 1'b0;
    end else if (!st_s && both_off) begin
      rearm_r <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Operating state machine
  always @(*) begin
    state_nxt = state_r;
    case (state_r)
      ST_OFF: begin
        if (pwr_r) state_nxt = ST_INIT;
      end
      ST_INIT: begin
        if (err_s || (done_s && !pass_s)) state_nxt = ST_ERR;
        else if (done_s && pass_s && swon_cnt >= SWON_CYC) state_nxt = ST_IDLE;
      end
      ST_IDLE: begin
        // Levels sampled each cycle here, so entry sees current inputs
        if (err_s) state_nxt = ST_ERR;
        else if (go) state_nxt = ST_RUN;
      end
      ST_RUN: begin
        if (err_s) state_nxt = ST_ERR;
        else if (!both_on) state_nxt = ST_IDLE;
      end
      ST_ERR: begin
        state_nxt = ST_ERR;
      end
      default: state_nxt = ST_ERR;
    endcase
    if (!pwr_r) state_nxt = ST_OFF;
  end

  always @(posedge clock) begin
    if (!rst_b) begin
      state_r <= ST_OFF;
      safety_out_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      // Output registered from the next state: one cycle response
      safety_out_r <= (state_nxt == ST_RUN);
    end
  end

  // Configuration only taken while off
  always @(posedge clock) begin
    if (!rst_b) begin
      cfg_r <= `SOSM_CFG_RST;
    end else if (cfg_we && state_r == ST_OFF) begin
      cfg_r <= cfg_data;
    end
  end
endmodule // sosm_ctrl
`default_nettype wire

// file: sosm_props.sv
`timescale 1ns/1ps
`default_nettype none
`include "sosm_defs.vh"
module sosm_props (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic power_on,
  input wire logic chan_a_in,
  input wire logic chan_b_in,
  input wire logic start_in,
  input wire logic selftest_done,
  input wire logic selftest_pass,
  input wire logic error_in,
  input wire logic cfg_we,
  input wire logic [`SOSM_CFG_W-1:0] cfg_data,
  input wire logic safety_out_r,
  input wire logic [4:0] state_r,
  input wire logic interlock_alert_r,
  input wire logic sync_fail_r,
  input wire logic [`SOSM_CFG_W-1:0] cfg_r
);
  default clocking @(posedge clock);
  endclocking
  default disable iff (!rst_b);
  // Pins need two edges to cross the synchronisers and a third to reach the state register
  sequence s_drop;
    (!chan_a_in || !chan_b_in) [*3];
  endsequence
  sequence s_err;
    (error_in && power_on) [*3];
  endsequence
  sequence s_pwr;
    power_on [*3];
  endsequence
  property p_out_st;
    safety_out_r == (state_r == 5'h08);
  endproperty
  a_out_st: assert property (p_out_st) else $error("output vs state");
  property p_pwr_off;
    !power_on [*3] |=> state_r == 5'h01 && !safety_out_r;
  endproperty
  a_pwr_off: assert property (p_pwr_off) else $error("power off");
  property p_enter;
    $rose(safety_out_r) |-> $past(state_r) == 5'h04 && $past(start_in, 3);
  endproperty
  a_enter: assert property (p_enter) else $error("bad energize");
  property p_drop;
    s_drop |=> !safety_out_r;
  endproperty
  a_drop: assert property (p_drop) else $error("late de-energize");
  property p_err_hold;
    s_pwr ##0 state_r == 5'h10 |=> state_r == 5'h10;
  endproperty
  a_err_hold: assert property (p_err_hold) else $error("error left");
  property p_err_in;
    s_err ##0 (state_r[1] || state_r[2] || state_r[3]) |=> state_r == 5'h10;
  endproperty
  a_err_in: assert property (p_err_in) else $error("error missed");
  property p_cfg_no;
    cfg_we && state_r != 5'h01 |=> $stable(cfg_r);
  endproperty
  a_cfg_no: assert property (p_cfg_no) else $error("cfg taken late");
  property p_cfg_yes;
    cfg_we && state_r == 5'h01 |=> cfg_r == $past(cfg_data);
  endproperty
  a_cfg_yes: assert property (p_cfg_yes) else $error("cfg lost");
endmodule // sosm_props
bind sosm_ctrl sosm_props sosm_props_i (
  .clock(clock),
  .rst_b(rst_b),
  .power_on(power_on),
  .chan_a_in(chan_a_in),
  .chan_b_in(chan_b_in),
  .start_in(start_in),
  .selftest_done(selftest_done),
  .selftest_pass(selftest_pass),
  .error_in(error_in),
  .cfg_we(cfg_we),
  .cfg_data(cfg_data),
  .safety_out_r(safety_out_r),
  .state_r(state_r),
  .interlock_alert_r(interlock_alert_r),
  .sync_fail_r(sync_fail_r),
  .cfg_r(cfg_r)
);
`default_nettype wire

// file: sosm_oper.sv
`timescale 1ns/1ps
`default_nettype none
module sosm_oper (
  input wire logic [2:0] want,
  output logic chan_a_in,
  output logic chan_b_in,
  output logic start_in
);
  // Contacts follow the operator at once; the bench moves want off the edge,
  // so no second sampling process can race it. Release before re-press is
  // up to the caller.
  assign {start_in, chan_b_in, chan_a_in} = want;
endmodule // sosm_oper
`default_nettype wire

// file: sosm_ctrl_tb.sv
`timescale 1ns/1ps
`default_nettype none
module sosm_ctrl_tb;
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic power_on = 1'b0;
  logic selftest_done = 1'b0;
  logic selftest_pass = 1'b0;
  logic error_in = 1'b0;
  logic cfg_we = 1'b0;
  logic [1:0] cfg_data = 2'h0;
  logic [2:0] want = 3'h0;
  wire chan_a_in, chan_b_in, start_in, safety_out_r, interlock_alert_r, sync_fail_r;
  wire [4:0] state_r;
  wire [1:0] cfg_r;
  int n_mismatch = 0;
  int comparisons = 0;
  // 125 MHz
  always #4 clock = ~clock;
  // Short counts keep the run brief
  sosm_ctrl #(.SYNC_SHORT_CYC(20), .SYNC_LONG_CYC(40), .INTLK_CYC(10), .INTLK_CLR_CYC(30),
    .SWON_CYC(5)) sosm_ctrl_i (.*);
  sosm_oper sosm_oper_i (
    .want(want),
    .chan_a_in(chan_a_in),
    .chan_b_in(chan_b_in),
    .start_in(start_in)
  );
  task report_and_stop;
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task chk(input string what, input logic [4:0] exp, input logic [4:0] got);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task wt(input int n);
    repeat (n) @(negedge clock);
  endtask
  // Bounded wait for a state
  task wst(input logic [4:0] exp);
    for (int i = 0; i < 300 && state_r !== exp; i++) wt(1);
    chk("state wait", exp, state_r);
    if (state_r !== exp) report_and_stop;
  endtask
  task cfg(input logic [1:0] d);
    cfg_data = d;
    cfg_we = 1'b1;
    wt(1);
    cfg_we = 1'b0;
  endtask
  // Release all, first channel, both after gap, then start
  task go(input logic [2:0] first, input int gap, input logic [4:0] exp);
    want = 3'h0;
    wt(6);
    want = first;
    wt(gap);
    want = 3'h3;
    wt(3);
    chk("state", 5'h04, state_r);
    want = 3'h7;
    wt(6);
    chk("state", exp, state_r);
    chk("out", {4'h0, exp[3]}, {4'h0, safety_out_r});
  endtask
  task s_boot;
    cfg(2'h3);
    chk("cfg", 5'h03, {3'h0, cfg_r});
    power_on = 1'b1;
    wst(5'h02);
    selftest_done = 1'b1;
    selftest_pass = 1'b1;
    wst(5'h04);
    cfg(2'h0);
    chk("cfg", 5'h03, {3'h0, cfg_r});
  endtask
  task s_run;
    want = 3'h4;
    wt(8);
    chk("state", 5'h04, state_r);
    go(3'h1, 3, 5'h08);
    want = 3'h1;
    wt(4);
    chk("state", 5'h04, state_r);
    // Alert trails the drop by sync, window and its own register
    wt(12);
    chk("alert", 5'h01, {4'h0, interlock_alert_r});
    go(3'h1, 3, 5'h04);
    want = 3'h0;
    wt(20);
    chk("alert", 5'h01, {4'h0, interlock_alert_r});
    wt(16);
    chk("alert", 5'h00, {4'h0, interlock_alert_r});
    go(3'h1, 3, 5'h08);
    // B drops and returns while start stays held: no restart, early return alerts
    want = 3'h5;
    wt(4);
    chk("state", 5'h04, state_r);
    want = 3'h7;
    wt(6);
    chk("state", 5'h04, state_r);
    chk("alert", 5'h01, {4'h0, interlock_alert_r});
    want = 3'h0;
    wt(36);
    chk("alert", 5'h00, {4'h0, interlock_alert_r});
  endtask
  task s_sync;
    go(3'h1, 25, 5'h04);
    chk("sync", 5'h01, {4'h0, sync_fail_r});
    go(3'h2, 25, 5'h08);
  endtask
  task s_err;
    error_in = 1'b1;
    wt(4);
    chk("state", 5'h10, state_r);
    error_in = 1'b0;
    wt(8);
    chk("state", 5'h10, state_r);
    power_on = 1'b0;
    wt(4);
    chk("state", 5'h01, state_r);
  endtask
  initial begin
    wt(3);
    rst_b = 1'b1;
    s_boot;
    s_run;
    s_sync;
    s_err;
    report_and_stop;
  end
endmodule // sosm_ctrl_tb
`default_nettype wire
